// *** design/lsd_driver_top.sv ***
// LED sink driver digital core with fault detection and power-saving
`timescale 1ns/10ps
`default_nettype none
module lsd_driver_top
(
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        serial_in_i,
    input  wire logic        latch_mode_pin_i,
    input  wire logic        enable_mode_pin_i,
    input  wire logic [15:0] current_low_i,
    input  wire logic [15:0] voltage_high_i,
    output logic             serial_out_o,
    output logic      [15:0] led_sink_channel_o,
    output logic             power_save_o,
    output logic             detect_mode_o
);
    logic             mode;
    logic      [15:0] healthy;
    logic      [15:0] shift_reg;
    logic      [15:0] latch_reg;
    logic      [15:0] result_reg;
    logic      [6:0]  det_cnt;
    lsd_pkg::lsd_det_t det_state;
    logic             save;
    logic             mode_q;
    logic      [15:0] chan_q;

    logic      [15:0] next_shift_reg;
    logic      [15:0] next_latch_reg;
    logic      [15:0] next_result_reg;
    logic      [6:0]  next_det_cnt;
    lsd_pkg::lsd_det_t next_det_state;
    logic             next_save;
    logic      [15:0] next_chan;

    lsd_mode_detect u_mode
    (
        .ref_clk_i         (ref_clk_i),
        .resetn_i          (resetn_i),
        .enable_mode_pin_i (enable_mode_pin_i),
        .latch_mode_pin_i  (latch_mode_pin_i),
        .detect_mode_o     (mode)
    );

    lsd_fault_eval u_eval
    (
        .current_low_i  (current_low_i),
        .voltage_high_i (voltage_high_i),
        .healthy_o      (healthy)
    );

    always_comb
    begin
        next_shift_reg  = {shift_reg[14:0], serial_in_i};
        next_latch_reg  = latch_reg;
        next_result_reg = result_reg;
        next_det_cnt    = det_cnt;
        next_det_state  = det_state;
        // Latch is level sensitive; sampled per edge here
        if (latch_mode_pin_i)
        begin
            // Transparent latch also sees the bit shifted in at this edge
            next_latch_reg = {shift_reg[14:0], serial_in_i};
        end
        case (det_state)
            lsd_pkg::ST_IDLE:
            begin
                next_det_cnt = 7'h00;
                if (mode && !enable_mode_pin_i)
                begin
                    next_det_state = lsd_pkg::ST_TESTING;
                end
            end
            lsd_pkg::ST_TESTING:
            begin
                if (det_cnt != lsd_pkg::DETECT_CNT_MAX)
                begin
                    next_det_cnt = det_cnt + 7'h01;
                end
                // Results only trusted once the minimum test time has run
                if (enable_mode_pin_i)
                begin
                    next_det_state = (det_cnt == lsd_pkg::DETECT_CNT_MAX) ?
                                     lsd_pkg::ST_DONE : lsd_pkg::ST_IDLE;
                end
                else
                begin
                    next_result_reg = healthy;
                end
            end
            lsd_pkg::ST_DONE:
            begin
                next_shift_reg = result_reg;
                next_det_state = lsd_pkg::ST_LOADED;
            end
            lsd_pkg::ST_LOADED:
            begin
                if (!mode)
                begin
                    next_det_state = lsd_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_det_state = lsd_pkg::ST_IDLE;
            end
        endcase
        next_save = (next_latch_reg == lsd_pkg::RESET_DATA);
        // Channels on only with enable low; off during power-saving
        next_chan = (enable_mode_pin_i || next_save) ? 16'h0000 : next_latch_reg;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            shift_reg  <= lsd_pkg::RESET_DATA;
            latch_reg  <= lsd_pkg::RESET_DATA;
            result_reg <= lsd_pkg::HEALTHY_ALL;
            det_cnt    <= 7'h00;
            det_state  <= lsd_pkg::ST_IDLE;
            save       <= 1'b1;
            mode_q     <= 1'b0;
            chan_q     <= 16'h0000;
        end
        else
        begin
            shift_reg  <= next_shift_reg;
            latch_reg  <= next_latch_reg;
            result_reg <= next_result_reg;
            det_cnt    <= next_det_cnt;
            det_state  <= next_det_state;
            save       <= next_save;
            mode_q     <= mode;
            chan_q     <= next_chan;
        end
    end

    always_comb
    begin
        serial_out_o       = shift_reg[15];
        led_sink_channel_o = chan_q;
        power_save_o       = save;
        detect_mode_o      = mode_q;
    end
endmodule
`default_nettype wire

// *** pkg/lsd_pkg.sv ***
// Constants and types for the LED sink driver fault-detection logic
package lsd_pkg;
    localparam int CHANNELS = 16;
    localparam int PAT_LEN = 5;
    localparam logic [4:0] PAT_ENABLE = 5'h1D;
    localparam logic [4:0] PAT_LATCH_ENTER = 5'h08;
    localparam logic [4:0] PAT_LATCH_LEAVE = 5'h00;
    localparam int DETECT_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DETECT_CYCLES = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] RESET_DATA = 16'h0000;
    localparam logic [15:0] HEALTHY_ALL = 16'hFFFF;
    localparam logic [6:0] DETECT_CNT_MAX = 7'h64;

    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'h0,
        ST_TESTING = 2'h1,
        ST_DONE    = 2'h3,
        ST_LOADED  = 2'h2
    } lsd_det_t;

    function automatic logic pattern_hit(input logic [4:0] en_hist,
                                         input logic [4:0] le_hist,
                                         input logic [4:0] le_pat);
        pattern_hit = (en_hist == PAT_ENABLE) && (le_hist == le_pat);
    endfunction
endpackage

// *** design/lsd_mode_detect.sv ***
// Mode pattern recogniser for the enable and latch pins
`timescale 1ns/10ps
`default_nettype none
module lsd_mode_detect
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic enable_mode_pin_i,
    input  wire logic latch_mode_pin_i,
    output logic      detect_mode_o
);
    logic [4:0] en_hist;
    logic [4:0] le_hist;
    logic       mode;
    logic [4:0] next_en_hist;
    logic [4:0] next_le_hist;
    logic       next_mode;

    always_comb
    begin
        // Newest sample enters at the top so bit 0 holds the first cycle
        next_en_hist = {enable_mode_pin_i, en_hist[4:1]};
        next_le_hist = {latch_mode_pin_i, le_hist[4:1]};
        next_mode    = mode;
        // History cleared on a hit so overlapping patterns cannot double count
        if (!mode && lsd_pkg::pattern_hit(next_en_hist, next_le_hist, lsd_pkg::PAT_LATCH_ENTER))
        begin
            next_mode    = 1'b1;
            next_en_hist = 5'h00;
            next_le_hist = 5'h00;
        end
        else if (mode && lsd_pkg::pattern_hit(next_en_hist, next_le_hist,
                                              lsd_pkg::PAT_LATCH_LEAVE))
        begin
            next_mode    = 1'b0;
            next_en_hist = 5'h00;
            next_le_hist = 5'h00;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            en_hist <= 5'h00;
            le_hist <= 5'h00;
            mode    <= 1'b0;
        end
        else
        begin
            en_hist <= next_en_hist;
            le_hist <= next_le_hist;
            mode    <= next_mode;
        end
    end

    assign detect_mode_o = mode;
endmodule
`default_nettype wire

// *** design/lsd_fault_eval.sv ***
// Per-channel fault evaluation from analog comparator flags
`timescale 1ns/10ps
`default_nettype none
module lsd_fault_eval
(
    input  wire logic [15:0] current_low_i,
    input  wire logic [15:0] voltage_high_i,
    output logic      [15:0] healthy_o
);
    // Comparators decide the thresholds; a set flag means a fault
    always_comb
    begin
        healthy_o = ~(current_low_i | voltage_high_i);
    end
endmodule
`default_nettype wire

// *** verification/lsd_driver_top_assertions.sv ***
// Pin-level assertions for the LED sink driver core
`timescale 1ns/10ps
`default_nettype none
module lsd_driver_top_assertions
(
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic        serial_in_i,
    input wire logic        latch_mode_pin_i,
    input wire logic        enable_mode_pin_i,
    input wire logic        serial_out_o,
    input wire logic [15:0] led_sink_channel_o,
    input wire logic        power_save_o,
    input wire logic        detect_mode_o
);
    wire        en = enable_mode_pin_i;
    wire        le = latch_mode_pin_i;
    wire        dm = detect_mode_o;
    logic [4:0] quiet;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // Result loads upset the chain, so trust it only well after detection
    always_ff @(posedge ref_clk_i or negedge resetn_i)
        if (!resetn_i)
            quiet <= 5'h00;
        else
            quiet <= dm ? 5'h00 : quiet + {4'h0, quiet != 5'h1F};
    a_enter_detect: assert property (
        !dm && en && !le ##1 !dm && !en && !le ##1 en && !le ##1 en && le ##1 en && !le
        |-> ##2 dm) else $error("entry pattern not taken");
    a_entry_ignored: assert property (
        dm && en && !le ##1 dm && !en && !le ##1 en && !le ##1 en && le ##1 en && !le
        |-> ##2 dm) else $error("entry pattern left detection");
    a_leave_detect: assert property (
        dm && en && !le ##1 dm && !en && !le ##1 (en && !le) [*3] |-> ##2 !dm)
        else $error("return pattern not taken");
    a_return_ignored: assert property (
        !dm && en && !le ##1 !dm && !en && !le ##1 (en && !le) [*3] |-> ##2 !dm)
        else $error("return pattern entered detection");
    a_outputs_off: assert property (en |=> led_sink_channel_o == 16'h0000)
        else $error("channel on while disabled");
    a_shift_chain: assert property (quiet >= 5'h12 |-> serial_out_o == $past(serial_in_i, 16))
        else $error("serial chain delay wrong");
    a_save_dark: assert property (
        power_save_o && $past(power_save_o) |-> $past(led_sink_channel_o) == 16'h0000)
        else $error("power save with channel on");
    a_reset_state: assert property ($rose(resetn_i) |-> power_save_o && !dm
        && !serial_out_o && led_sink_channel_o == 16'h0000) else $error("bad reset state");
endmodule
bind lsd_driver_top lsd_driver_top_assertions u_chk (.ref_clk_i, .resetn_i, .serial_in_i,
    .latch_mode_pin_i, .enable_mode_pin_i, .serial_out_o, .led_sink_channel_o,
    .power_save_o, .detect_mode_o);
`default_nettype wire

// *** verification/lsd_host_model.sv ***
// Host microcontroller model driving the serial and mode pins
`timescale 1ns/10ps
`default_nettype none
module lsd_host_model
(
    input  wire logic ref_clk_i,
    output logic      serial_in_o,
    output logic      latch_mode_pin_o,
    output logic      enable_mode_pin_o
);
    // Idle: outputs disabled, latch closed
    initial {serial_in_o, latch_mode_pin_o, enable_mode_pin_o} = 3'b001;
    // Pins change on the falling edge, held through the rising edge
    task automatic step(input logic s, input logic l, input logic e);
        @(negedge ref_clk_i);
        {serial_in_o, latch_mode_pin_o, enable_mode_pin_o} = {s, l, e};
        @(posedge ref_clk_i);
    endtask
    task automatic pattern(input logic [4:0] e, input logic [4:0] l);
        for (int i = 0; i < 5; i++)
            step(1'b0, l[i], e[i]);
    endtask
    // Latch pulse shares the last bit's edge; cascades just call this N times
    task automatic shift_word(input logic [15:0] d, input logic lat);
        for (int i = 15; i >= 0; i--)
            step(d[i], lat && i == 0, 1'b1);
    endtask
    task automatic fault_test(input int n);
        repeat (n)
            step(1'b0, 1'b0, 1'b0);
        repeat (2)
            step(1'b0, 1'b0, 1'b1);
    endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the LED sink driver core
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] cur_low = 16'h0000;
    logic [15:0] volt_high = 16'h0000;
    logic [15:0] word;
    logic [15:0] w1;
    logic [15:0] exp_q[$];
    wire         sin, le, en, sout, psave, dmode;
    wire  [15:0] chan;
    integer      seed = 13;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          nb = 0;
    always #5 clk = ~clk;
    lsd_host_model host (.ref_clk_i(clk), .serial_in_o(sin), .latch_mode_pin_o(le),
        .enable_mode_pin_o(en));
    lsd_driver_top dut (.ref_clk_i(clk), .resetn_i(resetn), .serial_in_i(sin),
        .latch_mode_pin_i(le), .enable_mode_pin_i(en), .current_low_i(cur_low),
        .voltage_high_i(volt_high), .serial_out_o(sout), .led_sink_channel_o(chan),
        .power_save_o(psave), .detect_mode_o(dmode));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic read_word(input logic [15:0] e);
        exp_q.push_back(e);
        rd = 1'b1;
        repeat (16)
            host.step(1'b0, 1'b0, 1'b1);
        rd = 1'b0;
    endtask
    // Words arrive top bit first
    always @(negedge clk)
        if (rd)
        begin
            word = {word[14:0], sout};
            nb++;
            if (nb == 16)
            begin
                nb = 0;
                chk("serial word", exp_q.pop_front(), word);
            end
        end
    initial
    begin
        w1 = 16'($random(seed));
        repeat (5)
            @(negedge clk);
        chk("reset flags", 16'h0004, {13'h0000, psave, dmode, sout});
        resetn = 1'b1;
        host.pattern(lsd_pkg::PAT_ENABLE, lsd_pkg::PAT_LATCH_LEAVE);
        host.shift_word(w1, 1'b1);
        read_word(w1);
        repeat (2)
            host.step(1'b0, 1'b0, 1'b0);
        chk("channels", w1, chan);
        chk("power save", {15'h0000, w1 == 16'h0000}, {15'h0000, psave});
        host.shift_word(16'h0000, 1'b1);
        repeat (2)
            host.step(1'b0, 1'b0, 1'b1);
        chk("power save", 16'h0001, {15'h0000, psave});
        for (int k = 0; k < 3; k++)
        begin
            host.pattern(lsd_pkg::PAT_ENABLE, lsd_pkg::PAT_LATCH_ENTER);
            host.shift_word(16'hFFFF, 1'b1);
            chk("detect mode", 16'h0001, {15'h0000, dmode});
            @(negedge clk);
            cur_low = (k == 1) ? 16'h0000 : 16'($random(seed));
            volt_high = (k == 2) ? 16'hFFFF : 16'($random(seed));
            host.fault_test(101 + k * 9);
            read_word(~(cur_low | volt_high));
            host.pattern(lsd_pkg::PAT_ENABLE, lsd_pkg::PAT_LATCH_ENTER);
            host.pattern(lsd_pkg::PAT_ENABLE, lsd_pkg::PAT_LATCH_LEAVE);
            repeat (3)
                host.step(1'b0, 1'b0, 1'b1);
            chk("detect mode", 16'h0000, {15'h0000, dmode});
        end
        print_verdict();
    end
    // Whole run is near 550 cycles; this allows several times that
    initial
    begin
        #30000;
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
